// ==== core/ied_dispatch.sv ====
// ied_dispatch: interrupt and exception dispatch for the core.
// assumes core event inputs are on I_MCLK; request pins and the
// acknowledge data bus are asynchronous and are synchronised here.
//
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module ied_dispatch (
  input  wire logic        I_MCLK,
  input  wire logic        I_RST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        I_NMI_PIN,
  input  wire logic        I_MASKABLE_REQUEST,
  input  wire logic        I_SYSTEM_MGMT_REQUEST,
  input  wire logic [7:0]  I_ACK_DATA,
  input  wire logic        I_BOUNDARY,
  input  wire logic        I_STR_WINDOW,
  input  wire logic        I_RETURN_FROM_HANDLER,
  input  wire logic        I_RET_IF,
  input  wire logic        I_HALT,
  input  wire logic        I_MGMT_EXIT,
  input  wire logic        I_SWI_VALID,
  input  wire logic [7:0]  I_SWI_VEC,
  input  wire logic        I_EXC_VALID,
  input  wire logic [7:0]  I_EXC_VEC,
  input  wire logic        I_DATA_BP,
  input  wire logic        I_INSTR_BP,
  input  wire logic [1:0]  I_GATE_TYPE,
  input  wire logic [31:0] I_CUR_IP,
  input  wire logic [31:0] I_NEXT_IP,
  output logic             O_DISPATCH,
  output logic      [7:0]  O_VECTOR,
  output logic      [1:0]  O_CLASS,
  output logic      [31:0] O_SAVED_IP,
  output logic             O_SAVED_IF,
  output logic             O_RESTARTABLE,
  output logic      [31:0] O_ENTRY_ADDR,
  output logic             O_LIMIT_ERR,
  output logic             O_MGMT_ENTRY,
  output logic             O_ACK_CYCLE,
  output logic             O_ACK_SECOND,
  output logic             O_ACK_LOCK,
  output logic             O_IF,
  output logic             O_HALTED
);
  // ==========================================================
  // state
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ACK1 = 3'b010,
    ST_ACK2 = 3'b100
  } ied_st_t;

  ied_st_t     st_reg, st_next;
  logic [2:0]  nmi_s_reg, nmi_s_next;
  logic [1:0]  int_s_reg, int_s_next, smi_s_reg, smi_s_next;
  logic [7:0]  ack_s1_reg, ack_s1_next, ack_s2_reg, ack_s2_next;
  logic [2:0]  cnt_reg, cnt_next;
  logic        if_reg, if_next, tf_reg, tf_next, pm_reg, pm_next;
  logic [31:0] base_reg, base_next;
  logic [15:0] limit_reg, limit_next;
  logic        nmi_act_reg, nmi_act_next, nmi_pnd_reg, nmi_pnd_next;
  logic [3:0]  depth_reg, depth_next;
  logic        halt_reg, halt_next, mgmt_reg, mgmt_next;
  logic        disp_reg, disp_next, mgent_reg, mgent_next;
  logic [7:0]  vec_reg, vec_next;
  logic [1:0]  cls_reg, cls_next;
  logic [31:0] sip_reg, sip_next, ent_reg, ent_next;
  logic        sif_reg, sif_next, rst_reg, rst_next;
  logic        lerr_reg, lerr_next;
  logic [31:0] ip_hold_reg, ip_hold_next;
  logic [31:0] prdata_reg, prdata_next;
  logic        pready_reg, pready_next, pslv_reg, pslv_next;
  logic        ack_reg, ack_next;

  // ==========================================================
  // vector class lookup
  function automatic logic [1:0] exc_class(input logic [7:0] v);
    logic [1:0] c;
    c = ied_pkg::CLS_FAULT;
    // aborts cannot restart
    // abort vectors
    if (v == ied_pkg::VEC_DBLF || v == ied_pkg::VEC_CSOV) begin
      c = ied_pkg::CLS_ABORT;
    end else if (v == ied_pkg::VEC_BRK || v == ied_pkg::VEC_OVF) begin
      c = ied_pkg::CLS_TRAP;
    end
    return c;
  endfunction
  logic        nmi_edge, int_ok, smi_req, apb_wr, apb_set;
  logic        take, wake;
  logic [7:0]  t_vec;
  logic [1:0]  t_cls;
  logic [31:0] t_ip;
  logic [10:0] off, last;

  // ==========================================================
  // dispatch, flags and bus
  always_comb begin
    st_next      = st_reg;
    nmi_s_next   = {nmi_s_reg[1:0], I_NMI_PIN};
    int_s_next   = {int_s_reg[0], I_MASKABLE_REQUEST};
    smi_s_next   = {smi_s_reg[0], I_SYSTEM_MGMT_REQUEST};
    ack_s1_next  = I_ACK_DATA;
    ack_s2_next  = ack_s1_reg;
    cnt_next     = cnt_reg;
    if_next      = if_reg;
    tf_next      = tf_reg;
    pm_next      = pm_reg;
    base_next    = base_reg;
    limit_next   = limit_reg;
    nmi_act_next = nmi_act_reg;
    nmi_pnd_next = nmi_pnd_reg;
    depth_next   = depth_reg;
    halt_next    = halt_reg;
    mgmt_next    = mgmt_reg;
    disp_next    = 1'b0;
    mgent_next   = 1'b0;
    vec_next     = vec_reg;
    cls_next     = cls_reg;
    sip_next     = sip_reg;
    sif_next     = sif_reg;
    rst_next     = rst_reg;
    ent_next     = ent_reg;
    lerr_next    = lerr_reg;
    ip_hold_next = ip_hold_reg;
    take         = 1'b0;
    t_vec        = vec_reg;
    t_cls        = cls_reg;
    t_ip         = I_NEXT_IP;
    // reads only the second and third stages
    nmi_edge = nmi_s_reg[1] & ~nmi_s_reg[2];
    int_ok   = int_s_reg[1] & if_reg;
    smi_req  = smi_s_reg[1] & ~mgmt_reg;

    if (nmi_edge) begin
      nmi_pnd_next = 1'b1;
    end

    // nmi cannot wake a halt inside its handler
    wake = smi_req | int_ok | (nmi_pnd_reg & ~nmi_act_reg);

    if (st_reg == ST_IDLE) begin
      if (I_EXC_VALID) begin
        take  = 1'b1;
        t_vec = I_EXC_VEC;
        t_cls = exc_class(I_EXC_VEC);
        t_ip  = I_CUR_IP;
      end else if (I_BOUNDARY && !halt_reg) begin
        // mgmt first, then debug and software traps, then instruction break, then nmi, then maskable
        if (smi_req) begin
          mgmt_next  = 1'b1;
          mgent_next = 1'b1;
        end else if (tf_reg || I_DATA_BP) begin
          // step and data break are traps
          take  = 1'b1;
          t_vec = ied_pkg::VEC_DEBUG;
          t_cls = ied_pkg::CLS_TRAP;
        end else if (I_SWI_VALID) begin
          take  = 1'b1;
          t_vec = I_SWI_VEC;
          t_cls = ied_pkg::CLS_TRAP;
        end else if (I_INSTR_BP) begin
          take  = 1'b1;
          t_vec = ied_pkg::VEC_DEBUG;
          t_cls = ied_pkg::CLS_FAULT;
          t_ip  = I_CUR_IP;
        end else if (nmi_pnd_reg && !nmi_act_reg) begin
          take         = 1'b1;
          t_vec        = ied_pkg::VEC_NMI;
          t_cls        = ied_pkg::CLS_MASKABLE_REQUEST;
          nmi_act_next = 1'b1;
          nmi_pnd_next = nmi_edge;
        end else if (int_ok) begin
          // saved pointer is the next instruction
          ip_hold_next = I_NEXT_IP;
          st_next      = ST_ACK1;
          cnt_next     = ied_pkg::ACK_LEN;
        end
      end else if (I_STR_WINDOW && int_ok && !halt_reg) begin
        ip_hold_next = I_CUR_IP;
        st_next      = ST_ACK1;
        cnt_next     = ied_pkg::ACK_LEN;
      end else if (halt_reg && wake) begin
        halt_next = 1'b0;
      end
    end else begin
      cnt_next = cnt_reg - 3'h1;
      if (cnt_reg == 3'h1) begin
        if (st_reg == ST_ACK1) begin
          st_next  = ST_ACK2;
          cnt_next = ied_pkg::ACK_LEN;
        end else begin
          // vector taken as supplied by the controller
          st_next = ST_IDLE;
          take    = 1'b1;
          t_vec   = ack_s2_reg;
          t_cls   = ied_pkg::CLS_MASKABLE_REQUEST;
          t_ip    = ip_hold_reg;
        end
      end
    end

    if (I_HALT) begin
      halt_next = 1'b1;
    end
    // an entry in the same cycle wins over the exit
    if (I_MGMT_EXIT && !mgent_next) begin
      mgmt_next = 1'b0;
    end

    // return restores flag and unwinds nesting
    if (I_RETURN_FROM_HANDLER) begin
      if_next = I_RET_IF;
      if (depth_reg != 4'h0) begin
        depth_next = depth_reg - 4'h1;
      end else begin
        // nmi handler itself returns, so nmi is no longer active
        nmi_act_next = 1'b0;
      end
    end

    // real mode 4 bytes, protected 8 bytes
    off  = pm_reg ? {t_vec, 3'h0} : {1'b0, t_vec, 2'h0};
    last = off + (pm_reg ? ied_pkg::ENT_LAST_PROT
                         : ied_pkg::ENT_LAST_REAL);

    // APB writes land before the hardware flag clear
    apb_set = PSEL & ~PENABLE;
    apb_wr  = PSEL & PENABLE & PWRITE & pready_reg;
    if (apb_wr) begin
      case (PADDR)
        ied_pkg::OFF_CTRL: begin
          if_next = PWDATA[ied_pkg::CTRL_IF];
          tf_next = PWDATA[ied_pkg::CTRL_TF];
          pm_next = PWDATA[ied_pkg::CTRL_PMODE];
        end
        ied_pkg::OFF_BASE:  base_next  = PWDATA;
        ied_pkg::OFF_LIMIT: limit_next = PWDATA[15:0];
        default: ;
      endcase
    end

    if (take) begin
      disp_next = 1'b1;
      vec_next  = t_vec;
      cls_next  = t_cls;
      sip_next  = t_ip;
      sif_next  = if_reg;
      rst_next  = (t_cls != ied_pkg::CLS_ABORT);
      // base plus scaled vector, checked on limit
      ent_next  = base_reg + {21'h0, off};
      lerr_next = ({5'h0, last} > limit_reg);
      if (nmi_act_reg) begin
        depth_next = depth_reg + 4'h1;
      end
      if (pm_reg && I_GATE_TYPE == ied_pkg::GATE_MASKABLE_REQUEST) begin
        if_next = 1'b0;
      end
    end

    ack_next    = (st_next != ST_IDLE);
    pready_next = apb_set;
    pslv_next   = apb_set && (PADDR > ied_pkg::OFF_STATUS ||
                              PADDR[1:0] != 2'h0);
    prdata_next = 32'h0;
    if (apb_set && !PWRITE) begin
      case (PADDR)
        ied_pkg::OFF_CTRL: begin
          prdata_next[ied_pkg::CTRL_IF]    = if_reg;
          prdata_next[ied_pkg::CTRL_TF]    = tf_reg;
          prdata_next[ied_pkg::CTRL_PMODE] = pm_reg;
        end
        ied_pkg::OFF_BASE:  prdata_next = base_reg;
        ied_pkg::OFF_LIMIT: prdata_next = {16'h0, limit_reg};
        ied_pkg::OFF_STATUS: begin
          prdata_next[ied_pkg::ST_VEC_LO +: 8] = vec_reg;
          prdata_next[ied_pkg::ST_CLS_LO +: 2] = cls_reg;
          prdata_next[ied_pkg::ST_NMI_ACT]     = nmi_act_reg;
          prdata_next[ied_pkg::ST_NMI_PND]     = nmi_pnd_reg;
          prdata_next[ied_pkg::ST_HALTED]      = halt_reg;
          prdata_next[ied_pkg::ST_LIM_ERR]     = lerr_reg;
          prdata_next[ied_pkg::ST_MGMT]        = mgmt_reg;
        end
        default: prdata_next = 32'h0;
      endcase
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      st_reg      <= ST_IDLE;
      nmi_s_reg   <= 3'h0;
      int_s_reg   <= 2'h0;
      smi_s_reg   <= 2'h0;
      ack_s1_reg  <= 8'h00;
      ack_s2_reg  <= 8'h00;
      cnt_reg     <= 3'h0;
      if_reg      <= 1'b0;
      tf_reg      <= 1'b0;
      pm_reg      <= 1'b0;
      base_reg    <= ied_pkg::TBL_BASE_RST;
      limit_reg   <= ied_pkg::TBL_LIMIT_RST;
      nmi_act_reg <= 1'b0;
      nmi_pnd_reg <= 1'b0;
      depth_reg   <= 4'h0;
      halt_reg    <= 1'b0;
      mgmt_reg    <= 1'b0;
      disp_reg    <= 1'b0;
      mgent_reg   <= 1'b0;
      vec_reg     <= 8'h00;
      cls_reg     <= 2'h0;
      sip_reg     <= 32'h0;
      sif_reg     <= 1'b0;
      rst_reg     <= 1'b0;
      ent_reg     <= 32'h0;
      lerr_reg    <= 1'b0;
      ip_hold_reg <= 32'h0;
      prdata_reg  <= 32'h0;
      pready_reg  <= 1'b0;
      pslv_reg    <= 1'b0;
      ack_reg     <= 1'b0;
    end else begin
      st_reg      <= st_next;
      nmi_s_reg   <= nmi_s_next;
      int_s_reg   <= int_s_next;
      smi_s_reg   <= smi_s_next;
      ack_s1_reg  <= ack_s1_next;
      ack_s2_reg  <= ack_s2_next;
      cnt_reg     <= cnt_next;
      if_reg      <= if_next;
      tf_reg      <= tf_next;
      pm_reg      <= pm_next;
      base_reg    <= base_next;
      limit_reg   <= limit_next;
      nmi_act_reg <= nmi_act_next;
      nmi_pnd_reg <= nmi_pnd_next;
      depth_reg   <= depth_next;
      halt_reg    <= halt_next;
      mgmt_reg    <= mgmt_next;
      disp_reg    <= disp_next;
      mgent_reg   <= mgent_next;
      vec_reg     <= vec_next;
      cls_reg     <= cls_next;
      sip_reg     <= sip_next;
      sif_reg     <= sif_next;
      rst_reg     <= rst_next;
      ent_reg     <= ent_next;
      lerr_reg    <= lerr_next;
      ip_hold_reg <= ip_hold_next;
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslv_reg    <= pslv_next;
      ack_reg     <= ack_next;
    end
  end

  // ack cycle and lock come from ack_reg and ack second from a state bit, so no gate sits before the pins
  assign PRDATA        = prdata_reg;
  assign PREADY        = pready_reg;
  assign PSLVERR       = pslv_reg;
  assign O_DISPATCH    = disp_reg;
  assign O_VECTOR      = vec_reg;
  assign O_CLASS       = cls_reg;
  assign O_SAVED_IP    = sip_reg;
  assign O_SAVED_IF    = sif_reg;
  assign O_RESTARTABLE = rst_reg;
  assign O_ENTRY_ADDR  = ent_reg;
  assign O_LIMIT_ERR   = lerr_reg;
  assign O_MGMT_ENTRY  = mgent_reg;
  assign O_ACK_CYCLE   = ack_reg;
  assign O_ACK_SECOND  = st_reg[2];
  assign O_ACK_LOCK    = ack_reg;
  assign O_IF          = if_reg;
  assign O_HALTED      = halt_reg;
endmodule
`default_nettype wire

// ==== shared/ied_pkg.sv ====
// ied_pkg: constants shared by the interrupt and exception dispatch block.
// assumes a 32-bit APB register window and 8-bit vector numbers.
package ied_pkg;
  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_BASE   = 8'h04;
  localparam logic [7:0] OFF_LIMIT  = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  // ctrl fields
  localparam int CTRL_IF    = 0;
  localparam int CTRL_TF    = 1;
  localparam int CTRL_PMODE = 2;
  // status fields
  localparam int ST_VEC_LO  = 0;
  localparam int ST_CLS_LO  = 8;
  localparam int ST_NMI_ACT = 10;
  localparam int ST_NMI_PND = 11;
  localparam int ST_HALTED  = 12;
  localparam int ST_LIM_ERR = 13;
  localparam int ST_MGMT    = 14;
  // ==========================================================
  // reset values of the vector table pointer
  localparam logic [31:0] TBL_BASE_RST  = 32'h0000_0000;
  localparam logic [15:0] TBL_LIMIT_RST = 16'h03FF;
  // ==========================================================
  // fixed vectors
  localparam logic [7:0] VEC_DIV   = 8'h00;
  localparam logic [7:0] VEC_DEBUG = 8'h01;
  localparam logic [7:0] VEC_NMI   = 8'h02;
  localparam logic [7:0] VEC_BRK   = 8'h03;
  localparam logic [7:0] VEC_OVF   = 8'h04;
  localparam logic [7:0] VEC_BOUND = 8'h05;
  localparam logic [7:0] VEC_DBLF  = 8'h08;
  localparam logic [7:0] VEC_CSOV  = 8'h09;
  // descriptor entry sizes minus one
  localparam logic [10:0] ENT_LAST_REAL = 11'h003;
  localparam logic [10:0] ENT_LAST_PROT = 11'h007;
  // ==========================================================
  // exception classes
  typedef enum logic [1:0] {
    CLS_TRAP  = 2'h0,
    CLS_FAULT = 2'h1,
    CLS_ABORT = 2'h2,
    CLS_MASKABLE_REQUEST  = 2'h3
  } ied_cls_t;
  // descriptor gate types
  localparam logic [1:0] GATE_MASKABLE_REQUEST = 2'h0;
  localparam logic [1:0] GATE_TRAP = 2'h1;
  localparam logic [1:0] GATE_TASK = 2'h2;
  // clocks per acknowledge bus cycle
  localparam logic [2:0] ACK_LEN = 3'h4;
endpackage

// ==== testbench/ied_dispatch_chk.sv ====
// ied_dispatch_chk: port-level assertions for the dispatch block.
// assumes it is bound onto ied_dispatch; inputs match its ports.
`timescale 1ns/1ps
`default_nettype none
module ied_dispatch_chk (
  input wire logic        I_MCLK,
  input wire logic        I_RST,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic [7:0]  I_ACK_DATA,
  input wire logic        I_EXC_VALID,
  input wire logic [7:0]  I_EXC_VEC,
  input wire logic        O_DISPATCH,
  input wire logic [7:0]  O_VECTOR,
  input wire logic [1:0]  O_CLASS,
  input wire logic        O_RESTARTABLE,
  input wire logic        O_ACK_CYCLE,
  input wire logic        O_ACK_SECOND,
  input wire logic        O_ACK_LOCK,
  input wire logic        O_IF,
  input wire logic        O_HALTED,
  input wire logic        O_MGMT_ENTRY
);
  default clocking cb @(posedge I_MCLK);
  endclocking
  default disable iff (I_RST);
  // ======================================================
  // acknowledge sequence
  a_ack_seq: assert property ($rose(O_ACK_CYCLE) |->
    (O_ACK_CYCLE && !O_ACK_SECOND)[*4] ##1 O_ACK_SECOND[*4] ##1 O_DISPATCH)
    else $error("ack sequence has wrong shape");
  a_ack_lock: assert property ((O_ACK_LOCK == O_ACK_CYCLE) &&
    !(O_ACK_CYCLE && O_DISPATCH))
    else $error("ack cycle not locked");
  a_ack_mask: assert property ($rose(O_ACK_CYCLE) |-> $past(O_IF))
    else $error("ack started with enable flag clear");
  a_ack_vector: assert property (O_DISPATCH && $past(O_ACK_SECOND) |->
    O_VECTOR == $past(I_ACK_DATA, 3) && O_CLASS == ied_pkg::CLS_MASKABLE_REQUEST)
    else $error("vector differs from ack data");
  // ======================================================
  // exceptions
  a_exc_take: assert property (I_EXC_VALID && !O_HALTED && !O_ACK_CYCLE
    && !O_DISPATCH |=> O_DISPATCH && O_VECTOR == $past(I_EXC_VEC))
    else $error("exception not dispatched on its vector");
  a_abort_cls: assert property (O_DISPATCH && O_CLASS == ied_pkg::CLS_ABORT
    |-> !O_RESTARTABLE && O_VECTOR inside {8'h08, 8'h09})
    else $error("abort class wrong");
  a_fault_restart: assert property (
    O_DISPATCH && O_CLASS == ied_pkg::CLS_FAULT |-> O_RESTARTABLE)
    else $error("fault not restartable");
  a_nmi_noack: assert property (O_DISPATCH && O_VECTOR == 8'h02 &&
    O_CLASS == ied_pkg::CLS_MASKABLE_REQUEST |-> !$past(O_ACK_SECOND))
    else $error("nmi used ack cycles");
  // ======================================================
  // register bus
  a_apb_ready: assert property (PSEL && PENABLE |-> PREADY)
    else $error("apb access not answered");
  a_apb_err: assert property (PSEL && PENABLE && PADDR > 8'h0C |->
    PSLVERR && PRDATA == 32'h0)
    else $error("unmapped access not refused");
  c_ack: cover property ($rose(O_ACK_CYCLE));
  c_nmi: cover property (O_DISPATCH && O_VECTOR == 8'h02);
  c_abort: cover property (O_DISPATCH && O_CLASS == ied_pkg::CLS_ABORT);
  c_mgmt: cover property (O_MGMT_ENTRY);
endmodule
bind ied_dispatch ied_dispatch_chk u_ied_dispatch_chk (.*);
`default_nettype wire

// ==== testbench/ied_pic_model.sv ====
// ied_pic_model: external controller that answers acknowledge cycles.
// assumes the dispatch block flags the second acknowledge cycle.
`timescale 1ns/1ps
`default_nettype none
module ied_pic_model (
  input  wire logic       i_ack_second,
  input  wire logic [7:0] i_vec,
  output logic      [7:0] o_ack_data
);
  // ======================================================
  // vector bus
  // vector in second cycle
  // the bench programs only vectors 32 to 255; off the second
  // cycle the bus shows the inverse so a stale sample cannot match
  always_comb begin
    if (i_ack_second) begin
      o_ack_data = i_vec;
    end else begin
      o_ack_data = ~i_vec;
    end
  end
endmodule
`default_nettype wire

// ==== testbench/testbench.sv ====
// testbench: directed run of the dispatch block over apb and core events.
// assumes the controller model drives the acknowledge vector bus.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        I_MCLK, I_RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic [7:0]  PADDR, I_ACK_DATA, I_SWI_VEC, I_EXC_VEC, O_VECTOR, pic_vec;
  logic [31:0] PWDATA, PRDATA, I_CUR_IP, I_NEXT_IP, O_SAVED_IP;
  logic [31:0] O_ENTRY_ADDR, rd;
  logic        I_NMI_PIN, I_MASKABLE_REQUEST, I_SYSTEM_MGMT_REQUEST;
  logic        I_BOUNDARY, I_STR_WINDOW, I_RETURN_FROM_HANDLER, I_RET_IF;
  logic        I_HALT, I_MGMT_EXIT, I_SWI_VALID, I_EXC_VALID, I_DATA_BP;
  logic        I_INSTR_BP, O_DISPATCH, O_SAVED_IF, O_RESTARTABLE;
  logic        O_LIMIT_ERR, O_MGMT_ENTRY, O_ACK_CYCLE, O_ACK_SECOND;
  logic        O_ACK_LOCK, O_IF, O_HALTED, got, mg, err, ab;
  logic [1:0]  I_GATE_TYPE, O_CLASS;
  logic [7:0]  xv [7];
  int          n_fail, num_checks;

  ied_dispatch u_ied_dispatch (.*);
  ied_pic_model u_ied_pic_model (
    .i_ack_second (O_ACK_SECOND),
    .i_vec        (pic_vec),
    .o_ack_data   (I_ACK_DATA)
  );

  initial begin
    I_MCLK = 1'b0;
    forever #50 I_MCLK = ~I_MCLK;
  end
  // ======================================================
  // tasks
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, e);
    num_checks++;
    if (s !== e) begin
      n_fail++;
      $display("unexpected %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge I_MCLK);
  endtask
  // an idle edge follows each transfer so psel is never set twice at once
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    PSEL   <= 1'b1;
    PWRITE <= w;
    PADDR  <= a;
    PWDATA <= d;
    @(posedge I_MCLK);
    PENABLE <= 1'b1;
    @(posedge I_MCLK);
    // ends once PREADY is seen high; the watchdog catches a hang
    while (PREADY !== 1'b1) @(posedge I_MCLK);
    rd  = PRDATA;
    err = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge I_MCLK);
  endtask
  // k: bit0 exception, bit1 software vector, bit2 string window
  task automatic ev(input logic [2:0] k, input logic [7:0] v);
    int n;
    I_EXC_VALID  <= k[0];
    I_SWI_VALID  <= k[1];
    I_STR_WINDOW <= k[2];
    I_BOUNDARY   <= ~(k[0] | k[2]);
    I_SWI_VEC    <= v;
    I_EXC_VEC    <= v;
    @(posedge I_MCLK);
    I_EXC_VALID  <= 1'b0;
    I_SWI_VALID  <= 1'b0;
    I_STR_WINDOW <= 1'b0;
    I_BOUNDARY   <= 1'b0;
    got = 1'b0;
    mg  = 1'b0;
    for (n = 0; n < 14 && !got && !mg; n++) begin
      @(posedge I_MCLK);
      got = (O_DISPATCH === 1'b1);
      mg  = (O_MGMT_ENTRY === 1'b1);
    end
  endtask
  task automatic pay(input logic [7:0] v, input logic [1:0] c,
                     input logic [31:0] ip);
    chk("dispatch", 32'(got), 32'h1);
    chk("vector", 32'(O_VECTOR), 32'(v));
    chk("class", 32'(O_CLASS), 32'(c));
    chk("saved ip", O_SAVED_IP, ip);
  endtask
  task automatic ret(input logic f);
    I_RETURN_FROM_HANDLER <= 1'b1;
    I_RET_IF              <= f;
    @(posedge I_MCLK);
    I_RETURN_FROM_HANDLER <= 1'b0;
    @(posedge I_MCLK);
  endtask
  // ======================================================
  // watchdog
  initial begin
    repeat (5000) @(posedge I_MCLK);
    n_fail++;
    close_out();
  end
  // ======================================================
  // main sequence
  initial begin
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA, I_NMI_PIN, I_MASKABLE_REQUEST,
     I_SYSTEM_MGMT_REQUEST, I_BOUNDARY, I_STR_WINDOW, I_RETURN_FROM_HANDLER,
     I_RET_IF, I_HALT, I_MGMT_EXIT, I_SWI_VALID, I_SWI_VEC, I_EXC_VALID,
     I_EXC_VEC, I_DATA_BP, I_INSTR_BP, I_GATE_TYPE} = '0;
    I_RST      = 1'b1;
    I_CUR_IP   = 32'h0000_0100;
    I_NEXT_IP  = 32'h0000_0104;
    pic_vec    = 8'h40;
    n_fail     = 0;
    num_checks = 0;
    xv = '{8'h00, 8'h05, 8'h06, 8'h08, 8'h09, 8'h0E, 8'h11};
    repeat (5) @(posedge I_MCLK);
    I_RST <= 1'b0;
    @(posedge I_MCLK);
    apb(1'b0, ied_pkg::OFF_BASE, 32'h0);
    chk("base", rd, 32'h0);
    apb(1'b0, ied_pkg::OFF_LIMIT, 32'h0);
    chk("limit", rd, 32'h0000_03FF);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped", 32'(err), 32'h1);
    apb(1'b1, ied_pkg::OFF_BASE, 32'h0000_1000);
    foreach (xv[i]) begin
      ev(3'b001, xv[i]);
      ab = xv[i] inside {8'h08, 8'h09};
      pay(xv[i], ab ? 2'h2 : 2'h1, 32'h100);
      chk("restart", 32'(O_RESTARTABLE), 32'(!ab));
      chk("entry", O_ENTRY_ADDR, 32'h1000 + 32'(xv[i]) * 4);
    end
    ev(3'b010, 8'hFF);
    pay(8'hFF, 2'h0, 32'h104);
    chk("limit err", 32'(O_LIMIT_ERR), 32'h0);
    apb(1'b1, ied_pkg::OFF_CTRL, 32'h4);
    ev(3'b010, 8'h80);
    chk("entry", O_ENTRY_ADDR, 32'h0000_1400);
    chk("limit err", 32'(O_LIMIT_ERR), 32'h1);
    ev(3'b010, 8'h03);
    pay(8'h03, 2'h0, 32'h104);
    apb(1'b1, ied_pkg::OFF_CTRL, 32'h6);
    ev(3'b000, 8'h00);
    pay(8'h01, 2'h0, 32'h104);
    apb(1'b1, ied_pkg::OFF_CTRL, 32'h4);
    I_INSTR_BP <= 1'b1;
    ev(3'b000, 8'h00);
    chk("vector", 32'(O_VECTOR), 32'h1);
    chk("class", 32'(O_CLASS), 32'h1);
    I_INSTR_BP <= 1'b0;
    I_DATA_BP  <= 1'b1;
    ev(3'b010, 8'h55);
    I_DATA_BP  <= 1'b0;
    pay(8'h01, 2'h0, 32'h104);
    // maskable path: masked, trap gate, then interrupt gate in a window
    I_MASKABLE_REQUEST <= 1'b1;
    cyc(4);
    ev(3'b000, 8'h00);
    chk("masked", 32'(got), 32'h0);
    apb(1'b1, ied_pkg::OFF_CTRL, 32'h5);
    I_GATE_TYPE <= 2'h1;
    ev(3'b000, 8'h00);
    pay(8'h40, 2'h3, 32'h104);
    chk("if kept", 32'(O_IF), 32'h1);
    pic_vec     <= 8'hC3;
    I_GATE_TYPE <= 2'h0;
    ev(3'b100, 8'h00);
    chk("vector", 32'(O_VECTOR), 32'hC3);
    chk("if clr", 32'(O_IF), 32'h0);
    chk("saved if", 32'(O_SAVED_IF), 32'h1);
    I_MASKABLE_REQUEST <= 1'b0;
    // non-maskable handling, nesting and halt
    I_NMI_PIN <= 1'b1;
    cyc(4);
    ev(3'b000, 8'h00);
    pay(8'h02, 2'h3, 32'h104);
    I_NMI_PIN <= 1'b0;
    cyc(3);
    I_NMI_PIN <= 1'b1;
    cyc(4);
    ev(3'b000, 8'h00);
    chk("nmi held", 32'(got), 32'h0);
    I_MASKABLE_REQUEST <= 1'b1;
    apb(1'b1, ied_pkg::OFF_CTRL, 32'h5);
    cyc(1);
    ev(3'b000, 8'h00);
    I_MASKABLE_REQUEST <= 1'b0;
    pay(8'hC3, 2'h3, 32'h104);
    ret(1'b1);
    apb(1'b0, ied_pkg::OFF_STATUS, 32'h0);
    chk("nmi active", 32'(rd[ied_pkg::ST_NMI_ACT]), 32'h1);
    chk("nmi pending", 32'(rd[ied_pkg::ST_NMI_PND]), 32'h1);
    ret(1'b1);
    ev(3'b000, 8'h00);
    pay(8'h02, 2'h3, 32'h104);
    I_NMI_PIN <= 1'b0;
    I_HALT    <= 1'b1;
    @(posedge I_MCLK);
    I_HALT    <= 1'b0;
    I_NMI_PIN <= 1'b1;
    cyc(5);
    chk("halt nmi", 32'(O_HALTED), 32'h1);
    apb(1'b1, ied_pkg::OFF_CTRL, 32'h5);
    I_MASKABLE_REQUEST <= 1'b1;
    cyc(5);
    chk("halt wake", 32'(O_HALTED), 32'h0);
    // management request outranks pending nmi and maskable
    I_SYSTEM_MGMT_REQUEST <= 1'b1;
    cyc(4);
    ev(3'b000, 8'h00);
    chk("mgmt first", 32'(mg), 32'h1);
    apb(1'b0, ied_pkg::OFF_STATUS, 32'h0);
    chk("mgmt mode", 32'(rd[ied_pkg::ST_MGMT]), 32'h1);
    I_SYSTEM_MGMT_REQUEST <= 1'b0;
    I_MASKABLE_REQUEST    <= 1'b0;
    I_MGMT_EXIT           <= 1'b1;
    @(posedge I_MCLK);
    I_MGMT_EXIT <= 1'b0;
    apb(1'b0, ied_pkg::OFF_STATUS, 32'h0);
    chk("mgmt left", 32'(rd[ied_pkg::ST_MGMT]), 32'h0);
    close_out();
  end
endmodule
`default_nettype wire
